// ==== link_tx_ctrl_pkg.sv ====
package link_tx_ctrl_pkg;

  // register offsets on the control port
  localparam logic [11:0] soft_sync_off     = 12'h203;
  localparam logic [11:0] link_control_off  = 12'h204;
  localparam logic [11:0] link_test_sel_off = 12'h205;
  localparam logic [11:0] link_ident_off    = 12'h206;
  localparam logic [11:0] frame_end_off     = 12'h207;
  localparam logic [11:0] link_state_off    = 12'h20f;

  // reset values
  localparam logic [7:0] soft_sync_rst     = 8'h01;
  localparam logic [7:0] link_control_rst  = 8'h03;
  localparam logic [7:0] link_test_sel_rst = 8'h00;
  localparam logic [7:0] link_ident_rst    = 8'h00;
  localparam logic [7:0] frame_end_rst     = 8'h00;

  // link_control field positions and register write masks
  localparam int scrambler_on_pos         = 0;
  localparam int sample_number_format_pos = 1;
  localparam int sync_sel_lo_pos          = 2;
  localparam int upper_lane_map_sel_pos   = 4;
  localparam logic [7:0] link_control_mask = 8'h1f;
  localparam logic [7:0] test_sel_mask     = 8'h1f;
  localparam logic [7:0] frame_end_mask    = 8'h03;
  localparam logic [7:0] ident_even_mask   = 8'hfe;

  // sync source codes
  localparam logic [1:0] sync_src_se_pin = 2'h0;
  localparam logic [1:0] sync_src_ts_pin = 2'h1;
  localparam logic [1:0] sync_src_soft   = 2'h2;

  typedef enum logic [4:0] {
    tst_normal = 5'h00, tst_prbs7 = 5'h01, tst_prbs15 = 5'h02, tst_prbs23 = 5'h03,
    tst_ramp = 5'h04, tst_transport = 5'h05, tst_d21_5 = 5'h06, tst_k28_5 = 5'h07,
    tst_rep_ila = 5'h08, tst_mod_rpat = 5'h09, tst_low = 5'h0a, tst_high = 5'h0b,
    tst_prbs9 = 5'h0d, tst_prbs31 = 5'h0e, tst_clock = 5'h0f, tst_k28_7 = 5'h10
  } test_code_e;

  // lane words for the static patterns
  localparam logic [15:0] clock_pattern_word = 16'h00ff;
  localparam logic [15:0] all_low_word       = 16'h0000;
  localparam logic [15:0] all_high_word      = 16'hffff;

  // end-of-frame comma control characters
  localparam logic [7:0] k28_7_char = 8'hfc;
  localparam logic [7:0] k28_1_char = 8'h3c;
  localparam logic [7:0] k28_5_char = 8'hbc;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] lane_on_a;
    logic [7:0] lane_on_b;
    logic       link_reset;
    logic       serializer_on;
    logic       link_clk_on;
  } lane_ctrl_s;

endpackage

// ==== link_tx_ctrl_regs.sv ====
// Added by the designer: strobed register access.
`timescale 1ns/1ps

module link_tx_ctrl_regs (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // control port
  input  wire link_tx_ctrl_pkg::bus_req_s    bus,
  output logic       [7:0]                   rdata,
  // sync pins, asynchronous
  input  wire logic                          single_ended_sync_pin,
  input  wire logic                          timestamp_pin,
  // neighbouring link logic, same clock
  input  wire logic                          link_interface_on,
  input  wire logic                          link_mode_64b66b,
  input  wire logic                          frame_end_slot,
  input  wire logic                          ila_second_mf,
  // link configuration out
  output link_tx_ctrl_pkg::lane_ctrl_s       lanes,
  output logic                               sync_request_n,
  output logic                               sample_number_format,
  output logic                               scramble_active,
  output link_tx_ctrl_pkg::test_code_e       test_mode,
  output logic       [15:0]                  test_word,
  output logic       [7:0]                   ila_ident_a,
  output logic       [7:0]                   ila_ident_b,
  output logic       [7:0]                   comma_char,
  output logic                               comma_insert
);

  typedef struct packed {
    logic [7:0]                    soft_sync;
    logic [7:0]                    link_control;
    logic [7:0]                    test_sel;
    logic [7:0]                    link_ident;
    logic [7:0]                    frame_end;
    logic [7:0]                    rdata;
    logic [1:0]                    se_sync;
    logic [1:0]                    ts_sync;
    link_tx_ctrl_pkg::lane_ctrl_s  lanes;
    logic                          sync_req_n;
    logic                          fmt;
    logic                          scrambler_on;
    link_tx_ctrl_pkg::test_code_e  tmode;
    logic [15:0]                   tword;
    logic [7:0]                    id_a;
    logic [7:0]                    id_b;
    logic [7:0]                    comma;
    logic                          comma_ins;
  } state_s;

  state_s st_q;
  state_s st_d;

  // reserved test codes fall back to normal data
  function automatic link_tx_ctrl_pkg::test_code_e decode_test(input logic [4:0] code);
    link_tx_ctrl_pkg::test_code_e t;
    t = link_tx_ctrl_pkg::tst_normal;
    if (code <= 5'h0b || (code >= 5'h0d && code <= 5'h10)) begin
      t = link_tx_ctrl_pkg::test_code_e'(code);
    end
    return t;
  endfunction

  function automatic logic [7:0] decode_comma(input logic [1:0] sel);
    logic [7:0] c;
    c = 8'h00;
    unique case (sel)
      2'h0: c = link_tx_ctrl_pkg::k28_7_char;
      2'h1: c = link_tx_ctrl_pkg::k28_1_char;
      2'h2: c = link_tx_ctrl_pkg::k28_5_char;
      2'h3: c = 8'h00;
    endcase
    return c;
  endfunction

  logic [1:0] sync_src;
  logic       upper_map;
  logic       pin_sync_n;
  logic [7:0] state_word;

  always_comb begin
    st_d = st_q;
    sync_src  = st_q.link_control[link_tx_ctrl_pkg::sync_sel_lo_pos +: 2];
    upper_map = st_q.link_control[link_tx_ctrl_pkg::upper_lane_map_sel_pos];

    // only the second stage is looked at by logic
    st_d.se_sync = {st_q.se_sync[0], single_ended_sync_pin};
    st_d.ts_sync = {st_q.ts_sync[0], timestamp_pin};

    if (bus.wr) begin
      unique case (bus.addr)
        link_tx_ctrl_pkg::soft_sync_off:
          st_d.soft_sync = {7'h00, bus.wdata[0]};
        link_tx_ctrl_pkg::link_control_off:
          st_d.link_control = bus.wdata & link_tx_ctrl_pkg::link_control_mask;
        link_tx_ctrl_pkg::link_test_sel_off:
          st_d.test_sel = bus.wdata & link_tx_ctrl_pkg::test_sel_mask;
        link_tx_ctrl_pkg::link_ident_off:
          st_d.link_ident = bus.wdata & link_tx_ctrl_pkg::ident_even_mask;
        link_tx_ctrl_pkg::frame_end_off:
          st_d.frame_end = bus.wdata & link_tx_ctrl_pkg::frame_end_mask;
        default: ;
      endcase
    end

    state_word = {2'h0, st_q.comma_ins, st_q.lanes.link_reset,
                  (st_q.tmode == link_tx_ctrl_pkg::tst_normal), st_q.fmt,
                  st_q.sync_req_n, st_q.scrambler_on};
    st_d.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        link_tx_ctrl_pkg::soft_sync_off:     st_d.rdata = st_q.soft_sync;
        link_tx_ctrl_pkg::link_control_off:  st_d.rdata = st_q.link_control;
        link_tx_ctrl_pkg::link_test_sel_off: st_d.rdata = st_q.test_sel;
        link_tx_ctrl_pkg::link_ident_off:    st_d.rdata = st_q.link_ident;
        link_tx_ctrl_pkg::frame_end_off:     st_d.rdata = st_q.frame_end;
        link_tx_ctrl_pkg::link_state_off:    st_d.rdata = state_word;
        default:                             st_d.rdata = 8'h00;
      endcase
    end

    // lanes and link power follow the interface enable
    st_d.lanes.link_reset    = !link_interface_on;
    st_d.lanes.serializer_on = link_interface_on;
    st_d.lanes.link_clk_on   = link_interface_on;
    st_d.lanes.lane_on_a     = 8'h00;
    st_d.lanes.lane_on_b     = 8'h00;
    if (link_interface_on) begin
      if (upper_map) begin
        st_d.lanes.lane_on_a = 8'hf0;
        st_d.lanes.lane_on_b = 8'hf0;
      end else begin
        st_d.lanes.lane_on_a = 8'h0f;
        st_d.lanes.lane_on_b = 8'h0f;
      end
    end

    // soft request always counts; pins only for their own source code
    unique case (sync_src)
      link_tx_ctrl_pkg::sync_src_se_pin: pin_sync_n = st_q.se_sync[1];
      link_tx_ctrl_pkg::sync_src_ts_pin: pin_sync_n = st_q.ts_sync[1];
      default:                           pin_sync_n = 1'b1;
    endcase
    st_d.sync_req_n = pin_sync_n & st_q.soft_sync[0];

    st_d.fmt = st_q.link_control[link_tx_ctrl_pkg::sample_number_format_pos];
    st_d.scrambler_on = link_mode_64b66b |
               st_q.link_control[link_tx_ctrl_pkg::scrambler_on_pos];

    st_d.tmode = decode_test(st_q.test_sel[4:0]);
    unique case (st_d.tmode)
      link_tx_ctrl_pkg::tst_low:   st_d.tword = link_tx_ctrl_pkg::all_low_word;
      link_tx_ctrl_pkg::tst_high:  st_d.tword = link_tx_ctrl_pkg::all_high_word;
      link_tx_ctrl_pkg::tst_clock: st_d.tword = link_tx_ctrl_pkg::clock_pattern_word;
      default:                     st_d.tword = link_tx_ctrl_pkg::all_low_word;
    endcase

    // identifiers shown only during the second ILA multiframe
    st_d.id_a = 8'h00;
    st_d.id_b = 8'h00;
    if (ila_second_mf && link_interface_on) begin
      st_d.id_a = st_q.link_ident;
      st_d.id_b = st_q.link_ident + 8'h01;
    end

    // comma goes out only where the stream offers a slot, never in 64b/66b
    st_d.comma     = decode_comma(st_q.frame_end[1:0]);
    st_d.comma_ins = frame_end_slot && link_interface_on && !link_mode_64b66b &&
                     (st_q.frame_end[1:0] != 2'h3);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q              <= '0;
      st_q.soft_sync    <= link_tx_ctrl_pkg::soft_sync_rst;
      st_q.link_control <= link_tx_ctrl_pkg::link_control_rst;
      st_q.test_sel     <= link_tx_ctrl_pkg::link_test_sel_rst;
      st_q.link_ident   <= link_tx_ctrl_pkg::link_ident_rst;
      st_q.frame_end    <= link_tx_ctrl_pkg::frame_end_rst;
      st_q.se_sync      <= 2'h3;
      st_q.ts_sync      <= 2'h3;
      st_q.sync_req_n   <= 1'b1;
      st_q.fmt          <= 1'b1;
      st_q.scrambler_on          <= 1'b1;
      st_q.lanes.link_reset <= 1'b1;
      st_q.tmode        <= link_tx_ctrl_pkg::tst_normal;
      st_q.comma        <= link_tx_ctrl_pkg::k28_7_char;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata                = st_q.rdata;
  assign lanes                = st_q.lanes;
  assign sync_request_n       = st_q.sync_req_n;
  assign sample_number_format = st_q.fmt;
  assign scramble_active      = st_q.scrambler_on;
  assign test_mode            = st_q.tmode;
  assign test_word            = st_q.tword;
  assign ila_ident_a          = st_q.id_a;
  assign ila_ident_b          = st_q.id_b;
  assign comma_char           = st_q.comma;
  assign comma_insert         = st_q.comma_ins;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_lane_map_normal: assert property (
    link_interface_on && !st_q.link_control[4] && !bus.wr |=>
      lanes.lane_on_a == 8'h0f && lanes.lane_on_b == 8'h0f)
    else $error("normal lane map wrong");

  chk_lane_map_upper: assert property (
    link_interface_on && st_q.link_control[4] && !bus.wr |=>
      lanes.lane_on_a == 8'hf0 && lanes.lane_on_b == 8'hf0)
    else $error("upper lane map wrong");

  chk_soft_sync_only: assert property (
    st_q.link_control[3:2] == 2'h2 && !bus.wr |=> sync_request_n == $past(st_q.soft_sync[0]))
    else $error("sync pins not ignored");

  chk_se_pin_sync: assert property (
    (st_q.link_control[3:2] == 2'h0 && st_q.soft_sync[0] && !single_ended_sync_pin) [*3]
      |=> !sync_request_n)
    else $error("single-ended pin sync not seen");

  chk_scramble_64b: assert property (
    link_mode_64b66b |=> scramble_active)
    else $error("64b/66b not scrambled");

  chk_ident_pair: assert property (
    ila_second_mf && link_interface_on |=> ila_ident_b == ila_ident_a + 8'h01)
    else $error("link B identifier not plus one");

  chk_ident_even: assert property (
    bus.rd && bus.addr == link_tx_ctrl_pkg::link_ident_off
      |=> rdata[0] == 1'b0)
    else $error("identifier bit 0 not zero");

  chk_comma_slot: assert property (
    comma_insert |-> $past(frame_end_slot) && !$past(link_mode_64b66b))
    else $error("comma outside a slot");

  chk_link_off_hold: assert property (
    !link_interface_on |=> lanes.link_reset && !lanes.serializer_on && !lanes.link_clk_on
      && lanes.lane_on_a == 8'h00 && lanes.lane_on_b == 8'h00)
    else $error("link not held while off");

  chk_reserved_test: assert property (
    st_q.test_sel[4:0] == 5'h0c || st_q.test_sel[4:0] > 5'h10 |=>
      test_mode == link_tx_ctrl_pkg::tst_normal)
    else $error("reserved test code not normal");

  chk_clock_pattern: assert property (
    test_mode == link_tx_ctrl_pkg::tst_clock |-> test_word == 16'h00ff)
    else $error("clock pattern word wrong");

  chk_ts_pin_sync: assert property (
    (st_q.link_control[3:2] == 2'h1 && st_q.soft_sync[0] && !timestamp_pin) [*3]
      |=> !sync_request_n)
    else $error("timestamp pin sync not seen");

  chk_format_bit: assert property (
    1'b1 |=> sample_number_format == $past(st_q.link_control[1]))
    else $error("sample format not from control bit");

  chk_scramble_8b: assert property (
    !link_mode_64b66b |=> scramble_active == $past(st_q.link_control[0]))
    else $error("8b/10b scrambling not from control bit");

  chk_comma_k28_7: assert property (
    st_q.frame_end[1:0] == 2'h0 |=> comma_char == link_tx_ctrl_pkg::k28_7_char)
    else $error("comma not K28.7");

  chk_comma_k28_1: assert property (
    st_q.frame_end[1:0] == 2'h1 |=> comma_char == link_tx_ctrl_pkg::k28_1_char)
    else $error("comma not K28.1");

  chk_comma_k28_5: assert property (
    st_q.frame_end[1:0] == 2'h2 |=> comma_char == link_tx_ctrl_pkg::k28_5_char)
    else $error("comma not K28.5");

  chk_comma_reserved: assert property (
    st_q.frame_end[1:0] == 2'h3 |=> !comma_insert)
    else $error("comma sent for reserved code");

  chk_word_high: assert property (
    test_mode == link_tx_ctrl_pkg::tst_high |-> test_word == 16'hffff)
    else $error("high pattern word wrong");

  chk_word_low: assert property (
    test_mode == link_tx_ctrl_pkg::tst_low |-> test_word == 16'h0000)
    else $error("low pattern word wrong");

  chk_ident_idle: assert property (
    !ila_second_mf |=> ila_ident_a == 8'h00 && ila_ident_b == 8'h00)
    else $error("identifier shown outside second multiframe");

  chk_ident_out_even: assert property (
    ila_second_mf && link_interface_on |=> !ila_ident_a[0])
    else $error("link A identifier odd");

  chk_soft_sync_req: assert property (
    !st_q.soft_sync[0] |=> !sync_request_n)
    else $error("soft sync request not seen");

  chk_link_on_power: assert property (
    link_interface_on |=> !lanes.link_reset && lanes.serializer_on && lanes.link_clk_on)
    else $error("link not released while on");

  chk_comma_link_off: assert property (
    !link_interface_on |=> !comma_insert)
    else $error("comma while link off");

  chk_comma_64b: assert property (
    link_mode_64b66b |=> !comma_insert)
    else $error("comma in 64b/66b mode");

endmodule

// ==== link_far_end.sv ====
`timescale 1ns/1ps
module link_far_end (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // commands from the bench
  input  wire logic ila_cmd,
  input  wire logic se_req,
  input  wire logic ts_req,
  // toward the block
  output logic      frame_end_slot,
  output logic      ila_second_mf,
  output logic      single_ended_sync_pin,
  output logic      timestamp_pin
);
  logic [1:0] slot_cnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) slot_cnt_q <= 2'h0;
    else slot_cnt_q <= slot_cnt_q + 2'h1;
  end
  // a comma slot only every fourth cycle, so insertion must wait for it
  assign frame_end_slot        = (slot_cnt_q == 2'h3);
  assign ila_second_mf         = ila_cmd;
  // sync pins are active low requests
  assign single_ended_sync_pin = ~se_req;
  assign timestamp_pin         = ~ts_req;
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module testbench;
  logic                         clk, rst_n, link_on, mode64, ila_cmd, se_req, ts_req;
  logic                         se_pin, ts_pin, slot, ila_mf, sync_n, fmt, scrambler_on, ins;
  link_tx_ctrl_pkg::bus_req_s   bus;
  link_tx_ctrl_pkg::lane_ctrl_s lanes;
  link_tx_ctrl_pkg::test_code_e tmode;
  logic [15:0]                  tword;
  logic [7:0]                   rdata, id_a, id_b, cchar, rd_v;
  int                           num_errors, tests_run, cycles, pulses;

  link_far_end far_end (.clk(clk), .rst_n(rst_n), .ila_cmd(ila_cmd), .se_req(se_req),
    .ts_req(ts_req), .frame_end_slot(slot), .ila_second_mf(ila_mf),
    .single_ended_sync_pin(se_pin), .timestamp_pin(ts_pin));
  link_tx_ctrl_regs uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .single_ended_sync_pin(se_pin), .timestamp_pin(ts_pin), .link_interface_on(link_on),
    .link_mode_64b66b(mode64), .frame_end_slot(slot), .ila_second_mf(ila_mf),
    .lanes(lanes), .sync_request_n(sync_n), .sample_number_format(fmt),
    .scramble_active(scrambler_on), .test_mode(tmode), .test_word(tword), .ila_ident_a(id_a),
    .ila_ident_b(id_b), .comma_char(cchar), .comma_insert(ins));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rd_v = rdata;
    `CHK(nm, e, rd_v)
  endtask
  task automatic set_link(input logic on);
    @(posedge clk);
    link_on <= on;
    cyc(3);
  endtask
  task automatic count_ins;
    pulses = 0;
    repeat (16) begin
      @(posedge clk);
      #1 pulses += ins;
    end
  endtask

  task automatic test_reset;
    rchk("link_control", link_tx_ctrl_pkg::link_control_off, 8'h03);
    rchk("test_sel", link_tx_ctrl_pkg::link_test_sel_off, 8'h00);
    rchk("ident", link_tx_ctrl_pkg::link_ident_off, 8'h00);
    rchk("frame_end", link_tx_ctrl_pkg::frame_end_off, 8'h00);
    rchk("unmapped", 12'h300, 8'h00);
    rchk("state_word", link_tx_ctrl_pkg::link_state_off, 8'h1f);
    `CHK("format", 1'b1, fmt)
    `CHK("comma_char", link_tx_ctrl_pkg::k28_7_char, cchar)
    `CHK("sync_idle", 1'b1, sync_n)
    $display("test reset done");
  endtask

  task automatic test_lanes;
    `CHK("off_lanes", 16'h0000, {lanes.lane_on_a, lanes.lane_on_b})
    `CHK("off_ctrl", 3'b100, {lanes.link_reset, lanes.serializer_on, lanes.link_clk_on})
    set_link(1'b1);
    `CHK("low_lanes", 16'h0f0f, {lanes.lane_on_a, lanes.lane_on_b})
    `CHK("on_ctrl", 3'b011, {lanes.link_reset, lanes.serializer_on, lanes.link_clk_on})
    set_link(1'b0);
    wr(link_tx_ctrl_pkg::link_control_off, 8'h13);
    set_link(1'b1);
    `CHK("high_lanes", 16'hf0f0, {lanes.lane_on_a, lanes.lane_on_b})
    set_link(1'b0);
    wr(link_tx_ctrl_pkg::link_control_off, 8'hff);
    rchk("ctrl_mask", link_tx_ctrl_pkg::link_control_off, 8'h1f);
    wr(link_tx_ctrl_pkg::link_control_off, 8'h00);
    cyc(3);
    `CHK("fmt_scr_off", 2'b00, {fmt, scrambler_on})
    @(posedge clk);
    mode64 <= 1'b1;
    cyc(3);
    `CHK("scr_64b", 1'b1, scrambler_on)
    @(posedge clk);
    mode64 <= 1'b0;
    wr(link_tx_ctrl_pkg::link_control_off, 8'h03);
    cyc(3);
    `CHK("fmt_scr_on", 2'b11, {fmt, scrambler_on})
    $display("test lanes done");
  endtask

  task automatic test_codes;
    logic [4:0] em;
    for (int c = 0; c < 32; c++) begin
      wr(link_tx_ctrl_pkg::link_test_sel_off, 8'(c));
      cyc(3);
      em = (c == 12 || c > 16) ? 5'h00 : 5'(c);
      `CHK("test_mode", em, tmode)
      `CHK("test_word", (c == 11) ? 16'hffff : (c == 15) ? 16'h00ff : 16'h0000, tword)
    end
    rchk("test_rb", link_tx_ctrl_pkg::link_test_sel_off, 8'h1f);
    wr(link_tx_ctrl_pkg::link_test_sel_off, 8'h00);
    $display("test codes done");
  endtask

  task automatic test_ident;
    wr(link_tx_ctrl_pkg::link_ident_off, 8'h07);
    rchk("ident_even", link_tx_ctrl_pkg::link_ident_off, 8'h06);
    set_link(1'b1);
    @(posedge clk);
    ila_cmd <= 1'b1;
    cyc(3);
    `CHK("ident_ab", 16'h0607, {id_a, id_b})
    @(posedge clk);
    ila_cmd <= 1'b0;
    cyc(3);
    `CHK("ident_idle", 16'h0000, {id_a, id_b})
    set_link(1'b0);
    $display("test ident done");
  endtask

  task automatic test_comma;
    logic [7:0] ce [4];
    ce = '{link_tx_ctrl_pkg::k28_7_char, link_tx_ctrl_pkg::k28_1_char,
           link_tx_ctrl_pkg::k28_5_char, 8'h00};
    for (int s = 0; s < 4; s++) begin
      wr(link_tx_ctrl_pkg::frame_end_off, 8'(s));
      set_link(1'b1);
      `CHK("comma_char", ce[s], cchar)
      count_ins();
      `CHK("comma_count", (s < 3) ? 4 : 0, pulses)
      @(posedge clk);
      mode64 <= 1'b1;
      cyc(2);
      count_ins();
      `CHK("comma_64b", 0, pulses)
      @(posedge clk);
      mode64 <= 1'b0;
      set_link(1'b0);
      count_ins();
      `CHK("comma_off", 0, pulses)
    end
    wr(link_tx_ctrl_pkg::frame_end_off, 8'h00);
    $display("test comma done");
  endtask

  task automatic test_sync;
    se_req <= 1'b1;
    cyc(5);
    `CHK("sync_se", 1'b0, sync_n)
    @(posedge clk);
    se_req <= 1'b0;
    ts_req <= 1'b1;
    cyc(5);
    `CHK("sync_ts_ignored", 1'b1, sync_n)
    wr(link_tx_ctrl_pkg::link_control_off, 8'h07);
    cyc(3);
    `CHK("sync_ts", 1'b0, sync_n)
    @(posedge clk);
    se_req <= 1'b1;
    ts_req <= 1'b0;
    cyc(5);
    `CHK("sync_se_ignored", 1'b1, sync_n)
    @(posedge clk);
    ts_req <= 1'b1;
    wr(link_tx_ctrl_pkg::link_control_off, 8'h0b);
    cyc(5);
    `CHK("sync_pins_ignored", 1'b1, sync_n)
    wr(link_tx_ctrl_pkg::soft_sync_off, 8'h00);
    cyc(3);
    `CHK("sync_soft", 1'b0, sync_n)
    rchk("soft_rb", link_tx_ctrl_pkg::soft_sync_off, 8'h00);
    wr(link_tx_ctrl_pkg::soft_sync_off, 8'h01);
    wr(link_tx_ctrl_pkg::link_control_off, 8'h03);
    se_req <= 1'b0;
    ts_req <= 1'b0;
    cyc(5);
    `CHK("sync_release", 1'b1, sync_n)
    $display("test sync done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is some five hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    bus = '0;
    rst_n = 1'b0;
    link_on = 1'b0;
    mode64 = 1'b0;
    ila_cmd = 1'b0;
    se_req = 1'b0;
    ts_req = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    test_reset();
    test_lanes();
    test_codes();
    test_ident();
    test_comma();
    test_sync();
    tally_and_finish();
  end
endmodule
